//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ir_xcvr_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] sel_pins_in;
  logic [2:0] sel_pins_out;
  logic [2:0] sel_pins_oe_n;
  logic primary_receive_pin;
  logic receiver_in;
  logic ir_transmit_out;
  logic rx_level = 1'h0;
  logic [7:0] rdata;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h03};
  logic [2:0] outs [5] = '{3'h5, 3'h3, 3'h2, 3'h6, 3'h0};
  logic [7:0] rxp [5] = '{8'h00, 8'h10, 8'h00, 8'h20, 8'h30};
  logic [7:0] alt [5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h08};
  logic rxe [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
  ir_transceiver_config DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sel_pins_in(sel_pins_in),
    .sel_pins_out(sel_pins_out),
    .sel_pins_oe_n(sel_pins_oe_n),
    .primary_receive_pin(primary_receive_pin),
    .receiver_in(receiver_in),
    .ir_transmit_out(ir_transmit_out)
  );
  xcvr_model xcvr (
    .sel_pins_out(sel_pins_out),
    .sel_pins_oe_n(sel_pins_oe_n),
    .rx_level(rx_level),
    .sel_pins_in(sel_pins_in),
    .primary_receive_pin(primary_receive_pin)
  );
  always #50 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [2:0] idx, input logic w,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 50);
    if (k >= 50) begin
      failures++;
      $display("[FAIL] %0t bus access never answered", $time);
    end
    rdata = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    bus(idx, 1'h1, d);
  endtask
  task automatic rd(input logic [2:0] idx);
    bus(idx, 1'h0, 8'h00);
  endtask
  task automatic pins(input logic [2:0] o, input logic [2:0] e);
    repeat (3) @(negedge clk_sys);
    chk({5'h0, sel_pins_out}, {5'h0, o});
    chk({5'h0, sel_pins_oe_n}, {5'h0, e});
  endtask
  // Counts cycles of the transmit pulse still to come
  task automatic pulse_len(output int len);
    int k;
    k = 0;
    len = 0;
    while (ir_transmit_out !== 1'h1 && k < 10) begin
      @(negedge clk_sys);
      k++;
    end
    while (ir_transmit_out === 1'h1 && len < 1000) begin
      @(negedge clk_sys);
      len++;
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    rd(IDX_RX_PATH_CFG);
    chk(rdata, 8'h00);
    rd(IDX_CONSUMER_CFG);
    chk(rdata, 8'h00);
    pins(3'h0, 3'h7);
    wr(IDX_RESERVED5, 8'hFF);
    rd(IDX_RESERVED5);
    chk(rdata, 8'h00);
    wr(3'h2, 8'hFF);
    rd(3'h2);
    chk(rdata, 8'h00);
    wr(IDX_CONSUMER_CFG, 8'h62);
    rd(IDX_CONSUMER_CFG);
    chk(rdata, 8'h62);
    wr(IDX_XCVR_CFG1, 8'h52);
    rd(IDX_XCVR_CFG1);
    chk(rdata, 8'h55);
    wr(IDX_RX_PATH_CFG, 8'h28);
    wr(IDX_XCVR_CFG1, 8'h53);
    pins(3'h3, 3'h0);
    rd(IDX_XCVR_CFG1);
    chk(rdata, 8'h53);
    wr(IDX_RX_PATH_CFG, 8'hA8);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_MODE_CTRL, modes[i]);
      pins(outs[i], 3'h0);
    end
    wr(IDX_MODE_CTRL, 8'h00);
    wr(IDX_RX_PATH_CFG, 8'h88);
    pins(3'h4, 3'h1);
    for (int i = 0; i < 5; i++) begin
      rx_level <= (i < 2);
      wr(IDX_RX_PATH_CFG, rxp[i]);
      wr(IDX_MODE_CTRL, alt[i]);
      repeat (3) @(negedge clk_sys);
      chk({7'h0, receiver_in}, {7'h0, rxe[i]});
    end
    wr(IDX_XCVR_CFG1, 8'h80);
    pulse_len(n);
    chk(8'(n / 10), 8'h40);
    wr(IDX_XCVR_CFG1, 8'h80);
    repeat (300) @(posedge clk_sys);
    wr(IDX_XCVR_CFG1, 8'h80);
    wr(IDX_XCVR_CFG1, 8'h00);
    rd(IDX_XCVR_CFG1);
    chk(rdata & 8'h80, 8'h80);
    pulse_len(n);
    chk({7'h0, n > 600 && n <= 640}, 8'h01);
    rd(IDX_XCVR_CFG1);
    chk(rdata & 8'h80, 8'h00);
    chk(n == 0 ? 8'h01 : 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- bench/xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_model #(
  // Identification levels are arbitrary
  parameter logic [2:0] ID_LEVELS = 3'h5
) (
  input wire logic [2:0] sel_pins_out,
  input wire logic [2:0] sel_pins_oe_n,
  input wire logic rx_level,
  output logic [2:0] sel_pins_in,
  output logic primary_receive_pin
);
  // A released pin shows the module's own identification level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sel_pins_in[i] = sel_pins_oe_n[i] ? ID_LEVELS[i] : sel_pins_out[i];
    end
  end
  assign primary_receive_pin = rx_level;
endmodule
`default_nettype wire

//--- rtl/ir_transceiver_config.sv
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_config (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ir_xcvr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] sel_pins_in,
  output logic [2:0] sel_pins_out,
  output logic [2:0] sel_pins_oe_n,
  input wire logic primary_receive_pin,
  output logic receiver_in,
  output logic ir_transmit_out
);
  import ir_xcvr_pkg::*;

  logic [7:0] cfg1_q;
  logic [7:0] cons_q;
  logic [7:0] rxp_q;
  logic [7:0] mode_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0] pin_val_d;
  logic [2:0] pin_dir;
  logic [2:0] sel_out_q;
  logic [2:0] sel_oe_n_q;
  logic rx_q;
  logic tx_q;
  logic wr_acc;
  logic rd_acc;
  logic lane0;
  logic [2:0] idx;
  logic [7:0] wd;
  logic auto_en;
  logic rx_sel;
  ir_mode_t mode;

  pulse_timer_if tmr_if ();

  tx_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tmr(tmr_if.timer)
  );

  // Picks one 3-bit field out of a configuration byte
  function automatic logic [2:0] field3(input logic [7:0] r,
                                        input int lsb);
    field3 = r[lsb +: 3];
  endfunction

  assign idx = avs_address[4:2];
  assign wd = avs_writedata[7:0];
  assign lane0 = avs_byteenable[0];
  // The request is served on the edge where waitrequest is seen low
  assign wr_acc = avs_write && !wait_q;
  assign rd_acc = avs_read && !wait_q;
  assign auto_en = rxp_q[RXP_AUTO_BIT];
  assign mode = ir_mode_t'(mode_q[MODE_LSB +: 2]);
  assign pin_dir = {rxp_q[RXP_DIR21_BIT], rxp_q[RXP_DIR21_BIT],
                    rxp_q[RXP_DIR0_BIT]};

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read mux; direct bits of input pins show the pin level
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (idx)
      IDX_MODE_CTRL: rdata_d[7:0] = mode_q;
      IDX_STATUS: rdata_d[7:0] = {3'h0, sel_pins_in, tx_q, rx_q};
      IDX_XCVR_CFG1: begin
        rdata_d[7:0] = cfg1_q;
        rdata_d[CFG1_PULSE_BIT] = tmr_if.busy;
        for (int i = 0; i < 3; i++) begin
          if (!pin_dir[i]) begin
            rdata_d[CFG1_DIRECT_LSB + i] = sel_pins_in[i];
          end
        end
      end
      IDX_RESERVED5: rdata_d = 32'h0000_0000;
      IDX_CONSUMER_CFG: rdata_d[7:0] = cons_q;
      IDX_RX_PATH_CFG: rdata_d[7:0] = rxp_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= RST_MODE;
    end else if (wr_acc && lane0 && idx == IDX_MODE_CTRL) begin
      mode_q <= wd & MODE_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxp_q <= RST_RXP;
    end else if (wr_acc && lane0 && idx == IDX_RX_PATH_CFG) begin
      rxp_q <= wd & RXP_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cons_q <= RST_CONS;
    end else if (wr_acc && lane0 && idx == IDX_CONSUMER_CFG) begin
      cons_q <= wd & CONS_MASK;
    end
  end

  // Direct bits store a write only while their pin is an output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg1_q <= RST_CFG1;
    end else if (wr_acc && lane0 && idx == IDX_XCVR_CFG1) begin
      cfg1_q[CFG1_SLOW_LSB +: 3] <= wd[CFG1_SLOW_LSB +: 3];
      for (int i = 0; i < 3; i++) begin
        if (pin_dir[i]) begin
          cfg1_q[CFG1_DIRECT_LSB + i] <= wd[CFG1_DIRECT_LSB + i];
        end
      end
    end
  end

  // Only a written one starts or restarts the pulse
  assign tmr_if.start = wr_acc && lane0 && idx == IDX_XCVR_CFG1
                        && wd[CFG1_PULSE_BIT];

  // Source of the select pin values
  always_comb begin
    pin_val_d = field3(cfg1_q, CFG1_DIRECT_LSB);
    if (auto_en) begin
      case (mode)
        MODE_SLOW_IR: pin_val_d = field3(cfg1_q, CFG1_SLOW_LSB);
        MODE_ASK_IR: pin_val_d = field3(cfg1_q, CFG1_DIRECT_LSB);
        MODE_CONSUMER_IR: begin
          if (mode_q[MODE_RANGE_BIT]) begin
            pin_val_d = field3(cons_q, CONS_HIGH_LSB);
          end else begin
            pin_val_d = field3(cons_q, CONS_LOW_LSB);
          end
        end
        default: pin_val_d = 3'h0;
      endcase
    end
  end

  // Input pins are released and drive low behind the disabled driver
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_out_q <= 3'h0;
      sel_oe_n_q <= 3'h7;
    end else begin
      sel_out_q <= pin_val_d & pin_dir;
      sel_oe_n_q <= ~pin_dir;
    end
  end

  // Receive source and polarity
  always_comb begin
    if (!mode_q[MODE_ALT_RX_BIT]) begin
      rx_sel = primary_receive_pin;
    end else if (rxp_q[RXP_DIR0_BIT]) begin
      rx_sel = 1'b1;
    end else begin
      rx_sel = sel_pins_in[0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_q <= 1'b0;
    end else begin
      rx_q <= rx_sel ^ rxp_q[RXP_INVERT_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_q <= 1'b0;
    end else begin
      tx_q <= tmr_if.busy;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign sel_pins_out = sel_out_q;
  assign sel_pins_oe_n = sel_oe_n_q;
  assign receiver_in = rx_q;
  assign ir_transmit_out = tx_q;

  // Checks
  localparam int PULSE_N = PULSE_CYCLES;
  logic [15:0] hi_cnt_q;
  logic pulse_wr;
  logic zero_wr;

  assign pulse_wr = tmr_if.start;
  assign zero_wr = wr_acc && lane0 && idx == IDX_XCVR_CFG1
                   && !wd[CFG1_PULSE_BIT];

  // Cycles the timer has stayed busy since its last start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= 16'h0000;
    end else if (pulse_wr) begin
      hi_cnt_q <= 16'h0000;
    end else if (tmr_if.busy) begin
      hi_cnt_q <= hi_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pulse_write;
    pulse_wr;
  endsequence

  sequence s_pulse_seen;
    ##1 tmr_if.busy ##1 ir_transmit_out;
  endsequence

  chk_pulse_start: assert property (
    s_pulse_write |-> s_pulse_seen)
    else $error("transmit pulse did not start");

  chk_pulse_length: assert property (
    $fell(tmr_if.busy) |-> hi_cnt_q == 16'(PULSE_N))
    else $error("transmit pulse length wrong");

  chk_pulse_restart: assert property (
    pulse_wr && tmr_if.busy |=> tmr_if.busy [*8])
    else $error("restart did not extend pulse");

  chk_zero_write: assert property (
    zero_wr && !tmr_if.busy |=> !tmr_if.busy ##1 !ir_transmit_out)
    else $error("writing zero started a pulse");

  chk_rx_select: assert property (
    1'b1 |=> receiver_in == ($past(mode_q[MODE_ALT_RX_BIT])
      ? ($past(rxp_q[RXP_DIR0_BIT]) ? 1'b1 : $past(sel_pins_in[0]))
      : $past(primary_receive_pin)) ^ $past(rxp_q[RXP_INVERT_BIT]))
    else $error("receive selection wrong");

  chk_pin_dir: assert property (
    1'b1 |=> sel_pins_oe_n == {~$past(rxp_q[RXP_DIR21_BIT]),
      ~$past(rxp_q[RXP_DIR21_BIT]), ~$past(rxp_q[RXP_DIR0_BIT])})
    else $error("pin direction wrong");

  chk_auto_slow: assert property (
    auto_en && mode == MODE_SLOW_IR && rxp_q[RXP_DIR21_BIT]
    |=> sel_pins_out[2:1] == $past(cfg1_q[6:5]))
    else $error("slow mode pins wrong");

  chk_consumer_low: assert property (
    auto_en && mode == MODE_CONSUMER_IR && !mode_q[MODE_RANGE_BIT]
    && pin_dir == 3'h7 |=> sel_pins_out == $past(cons_q[2:0]))
    else $error("consumer low pins wrong");

  chk_consumer_high: assert property (
    auto_en && mode == MODE_CONSUMER_IR && mode_q[MODE_RANGE_BIT]
    && pin_dir == 3'h7 |=> sel_pins_out == $past(cons_q[6:4]))
    else $error("consumer high pins wrong");

  chk_manual_direct: assert property (
    !auto_en && pin_dir == 3'h7 |=> sel_pins_out == $past(cfg1_q[2:0]))
    else $error("manual pins wrong");

  chk_reserved_read: assert property (
    avs_read && wait_q && idx == IDX_RESERVED5
    |=> !avs_waitrequest && avs_readdata == 32'h0000_0000)
    else $error("reserved slot read not zero");

  chk_cons_readback: assert property (
    rd_acc && idx == IDX_CONSUMER_CFG
    |-> avs_readdata[7:0] == cons_q)
    else $error("consumer field readback wrong");

  chk_id_read: assert property (
    avs_read && wait_q && idx == IDX_XCVR_CFG1 && !pin_dir[0]
    |=> avs_readdata[0] == $past(sel_pins_in[0]))
    else $error("input pin level not read back");

  chk_id_write: assert property (
    wr_acc && lane0 && idx == IDX_XCVR_CFG1 && pin_dir == 3'h0
    |=> $stable(cfg1_q[2:0]))
    else $error("write to input pin bits stored");

  chk_slow_bit0: assert property (
    auto_en && mode == MODE_SLOW_IR && !rxp_q[RXP_DIR0_BIT]
    |=> sel_pins_out[0] == 1'b0)
    else $error("slow field bit 0 drove an input pin");

  chk_amplitude_direct: assert property (
    auto_en && mode == MODE_ASK_IR && pin_dir == 3'h7
    |=> sel_pins_out == $past(cfg1_q[2:0]))
    else $error("amplitude mode pins wrong");
endmodule
`default_nettype wire

//--- rtl/ir_xcvr_pkg.sv
package ir_xcvr_pkg;
  // Register word indices, byte address is four times the index
  localparam logic [2:0] IDX_MODE_CTRL = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_XCVR_CFG1 = 3'h4;
  localparam logic [2:0] IDX_RESERVED5 = 3'h5;
  localparam logic [2:0] IDX_CONSUMER_CFG = 3'h6;
  localparam logic [2:0] IDX_RX_PATH_CFG = 3'h7;
  localparam int ADDR_W = 5;

  // Fields of ir_transceiver_config_one
  localparam int CFG1_DIRECT_LSB = 0;
  localparam int CFG1_SLOW_LSB = 4;
  localparam int CFG1_PULSE_BIT = 7;
  // Fields of consumer_ir_transceiver_config
  localparam int CONS_LOW_LSB = 0;
  localparam int CONS_HIGH_LSB = 4;
  // Fields of ir_receiver_path_config
  localparam int RXP_DIR21_BIT = 3;
  localparam int RXP_INVERT_BIT = 4;
  localparam int RXP_DIR0_BIT = 5;
  localparam int RXP_AUTO_BIT = 7;
  // Fields of the mode control register
  localparam int MODE_LSB = 0;
  localparam int MODE_RANGE_BIT = 2;
  localparam int MODE_ALT_RX_BIT = 3;

  // Writable bit masks; other bits read as zero, except the CFG1 pulse bit, which reads the timer busy flag
  localparam logic [7:0] CFG1_STORE_MASK = 8'h77;
  localparam logic [7:0] CONS_MASK = 8'h77;
  localparam logic [7:0] RXP_MASK = 8'hB8;
  localparam logic [7:0] MODE_MASK = 8'h0F;

  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [7:0] RST_CONS = 8'h00;
  localparam logic [7:0] RST_RXP = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;

  // Pulse timing
  localparam int CLK_KHZ = 10000;
  localparam int PULSE_US = 64;
  localparam int PULSE_CYCLES = (PULSE_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    MODE_SLOW_IR,
    MODE_ASK_IR,
    MODE_CONSUMER_IR,
    MODE_OTHER
  } ir_mode_t;
endpackage

//--- rtl/pulse_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pulse_timer_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface
`default_nettype wire

//--- rtl/tx_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tx_pulse_timer #(
  parameter int CYCLES = ir_xcvr_pkg::PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  pulse_timer_if.timer tmr
);
  import ir_xcvr_pkg::*;

  logic [$clog2(CYCLES+1)-1:0] cnt_q;
  logic busy_q;

  // Every start reloads the full count, so a pulse in progress is extended
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (tmr.start) begin
      cnt_q <= ($clog2(CYCLES+1))'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (tmr.start) begin
      busy_q <= 1'b1;
    end else if (cnt_q == 1) begin
      busy_q <= 1'b0;
    end
  end

  assign tmr.busy = busy_q;
endmodule
`default_nettype wire
